// ==== logic/fhrp_pkg.sv ====
package fhrp_pkg;

  // Timing
  localparam int SYS_CLK_MHZ        = 20;
  localparam int CLEAR_PULSE_MIN_NS = 1000;
  localparam int CLEAR_PULSE_CYC    = (CLEAR_PULSE_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int STATUS_WRITE_CMD_BUSY_CYC      = 16;
  localparam int PROG_BUSY_CYC      = 32;
  localparam int ERASE_BUSY_CYC     = 64;

  // Status field positions, bytes one to three packed as bits 23:0
  localparam int BUSY_BIT   = 0;
  localparam int WEL_BIT    = 1;
  localparam int AREA_LSB   = 2;
  localparam int STATUS_GUARD_BIT_ZERO_BIT   = 7;
  localparam int ADS_BIT    = 8;
  localparam int QE_BIT     = 9;
  localparam int PSUS_BIT   = 10;
  localparam int OTP_LSB    = 11;
  localparam int STATUS_GUARD_BIT_ONE_BIT   = 14;
  localparam int ESUS_BIT   = 15;
  localparam int DC_LSB     = 16;
  localparam int PE_BIT     = 18;
  localparam int EE_BIT     = 19;
  localparam int ADP_BIT    = 20;
  localparam int DRV_LSB    = 21;
  localparam int PINSEL_BIT = 23;

  localparam logic [23:0] NV_MASK  = 24'hf37afc;
  localparam logic [23:0] OTP_MASK = 24'h003800;
  localparam logic [23:0] NV_RESET = 24'h000000;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD     = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD     = 8'h04;
  localparam logic [7:0] OP_RDSR1    = 8'h05;
  localparam logic [7:0] OP_RDSR2    = 8'h35;
  localparam logic [7:0] OP_RDSR3    = 8'h15;
  localparam logic [7:0] OP_WRSR1    = 8'h01;
  localparam logic [7:0] OP_WRSR2    = 8'h31;
  localparam logic [7:0] OP_WRSR3    = 8'h11;
  localparam logic [7:0] OP_PP       = 8'h02;
  localparam logic [7:0] OP_SE       = 8'h20;
  localparam logic [7:0] OP_BE64     = 8'hd8;
  localparam logic [7:0] OP_CE_A     = 8'h60;
  localparam logic [7:0] OP_CE_B     = 8'hc7;
  localparam logic [7:0] OP_DPD      = 8'hb9;
  localparam logic [7:0] OP_DPD_EXIT = 8'hab;
  localparam logic [7:0] OP_EN4B     = 8'hb7;
  localparam logic [7:0] OP_EX4B     = 8'he9;
  localparam logic [7:0] OP_RST_EN   = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;

  // Array geometry
  localparam int ADDR_W  = 25;
  localparam int BLOCK_W = 9;

  // Pin synchroniser lanes
  localparam int SY_CS    = 0;
  localparam int SY_HOLD  = 1;
  localparam int SY_RST   = 2;
  localparam int SY_WP    = 3;
  localparam int SY_SCLK  = 4;
  localparam int SY_DRIVE = 5;
  localparam int SY_FRAME = 6;
  localparam logic [6:0] SYNC_RESET = 7'h0f;

  typedef enum logic [1:0] {
    FHRP_IDLE = 2'b00,
    FHRP_BUSY = 2'b01
  } fhrp_op_e;

endpackage : fhrp_pkg

// ==== logic/fhrp_sync.sv ====
module fhrp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage  <= RESET_VAL;
      synced <= RESET_VAL;
    end else begin
      stage  <= async;
      synced <= stage;
    end
  end

endmodule : fhrp_sync

// ==== logic/fhrp_area_guard.sv ====
module fhrp_area_guard #(
  parameter int BLOCK_W = 9
) (
  input  wire logic [4:0]         guard,
  input  wire logic [BLOCK_W-1:0] block,
  input  wire logic               wholeChip,
  output logic                    hit
);

  logic [BLOCK_W:0] count;
  logic             coverAll;

  always_comb begin
    coverAll = (guard[3] & guard[2] & ~guard[1]) | (guard[3] & guard[1]);
    count    = '0;
    if (guard[3:0] != 4'h0 && guard[3:0] <= 4'h9) begin
      count = {{BLOCK_W{1'b0}}, 1'b1} << (guard[3:0] - 4'h1);
    end
    if (coverAll) begin
      hit = 1'b1;
    end else if (count == '0) begin
      hit = 1'b0;
    end else if (wholeChip) begin
      hit = 1'b1;
    end else if (guard[4]) begin
      hit = {1'b0, block} < count;
    end else begin
      hit = {1'b0, block} >= ({1'b1, {BLOCK_W{1'b0}}} - count);
    end
  end

endmodule : fhrp_area_guard

// ==== logic/fhrp_flash_guard.sv ====
// What this block does
// (R1) With pin select 0 and quad enable 0 the shared pin is an active-low pause; quad enable 1 disables it.
// (R2) Pause stops only serial traffic; a running status write, program or erase carries on.
// (R3) Pause needs select low and starts at the pause fall with clock low, or later when clock goes low.
// (R4) Pause ends at the pause rise with clock low, or later when clock goes low.
// (R5) While paused the serial output floats and serial input and clock are ignored.
// (R6) Select rising during pause resets the interface; the host then releases pause and reselects.
// (R7) With pin select 1 and quad enable 0 the shared pin is an active-low hardware reset.
// (R8) The dedicated reset pin works whatever quad enable holds.
// (R9) Reset low for at least 1 us returns every volatile bit to its power-on value in standby.
// (R10) Write enable sets the latch; power-up, soft reset, disable, status write, program, erase clear it.
// (R11) Five area guard bits pick a protected upper or lower power-of-two run of 64KB blocks.
// (R12) With guard bit zero set, a low write-protect pin locks the area and status guard bits.
// (R13) In deep power-down only the release command and the soft reset pair are obeyed; the link still answers status reads.
// (R14) Status byte one: guard bit zero, five area bits, write latch, busy.
// (R15) Status byte two: erase paused, guard bit one, three lock bits, program paused, quad, width.
// (R16) Status byte three: pin select, drive strength, power-up width, errors, dummy select.
// (R17) Busy reads 1 exactly while a program, erase or status write runs.
module fhrp_flash_guard #(
  parameter int STATUS_WRITE_CMD_CYC  = fhrp_pkg::STATUS_WRITE_CMD_BUSY_CYC,
  parameter int PROG_CYC  = fhrp_pkg::PROG_BUSY_CYC,
  parameter int ERASE_CYC = fhrp_pkg::ERASE_BUSY_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic       si,
  input  wire logic       holdIoN,
  input  wire logic       resetPinN,
  input  wire logic       wpN,
  output logic            serialOut,
  output logic            serialOutOe,
  output logic            paused,
  output logic            busy,
  output logic [7:0]      statusByteOne,
  output logic [7:0]      statusByteTwo,
  output logic [7:0]      statusByteThree
);

  localparam int RCW = $clog2(fhrp_pkg::CLEAR_PULSE_CYC + 1);

  // Link side, on the serial clock
  logic        linkRst;
  logic [5:0]  bitCnt,    next_bitCnt;
  logic [7:0]  shiftIn,   next_shiftIn;
  logic        inFrame,   next_inFrame;
  logic [2:0]  byteCnt,   next_byteCnt;
  logic [7:0]  frameByte [5];
  logic [7:0]  next_frameByte [5];
  logic        frameTgl,  next_frameTgl;
  logic        linkDrive, next_linkDrive;
  logic        next_serialOut;
  logic [23:0] linkStatus;
  logic        linkPaused;
  logic [2:0]  byteIdx;
  logic [7:0]  readSel;
  logic        readOp;
  logic [23:0] statusAll, next_statusAll;

  assign linkRst = reset | csN;

  fhrp_sync #(.WIDTH(24), .RESET_VAL(24'h000000)) linkSync (
    .clk    (sclk),
    .reset  (reset),
    .async  (statusAll),
    .synced (linkStatus)
  );

  assign linkPaused = ~linkStatus[fhrp_pkg::PINSEL_BIT] & ~linkStatus[fhrp_pkg::QE_BIT]
                      & ~holdIoN; // R1
  assign byteIdx    = inFrame ? byteCnt : 3'h0;

  always_comb begin
    next_bitCnt  = bitCnt;
    next_shiftIn = shiftIn;
    next_inFrame = inFrame;
    if (!linkPaused) begin // R5
      next_bitCnt  = bitCnt + 6'h01;
      next_shiftIn = {shiftIn[6:0], si};
      next_inFrame = 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin // R6
      bitCnt  <= 6'h00;
      shiftIn <= 8'h00;
      inFrame <= 1'b0;
    end else begin
      bitCnt  <= next_bitCnt;
      shiftIn <= next_shiftIn;
      inFrame <= next_inFrame;
    end
  end

  always_comb begin
    next_byteCnt   = byteCnt;
    next_frameTgl  = frameTgl;
    next_frameByte = frameByte;
    if (!linkPaused) begin // R5
      if (!inFrame) begin
        next_frameTgl = ~frameTgl;
        next_byteCnt  = 3'h0;
      end
      if (bitCnt[2:0] == 3'h7 && byteIdx < 3'h5) begin
        next_frameByte[byteIdx] = {shiftIn[6:0], si};
        next_byteCnt            = byteIdx + 3'h1;
      end
    end
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      byteCnt   <= 3'h0;
      frameTgl  <= 1'b0;
      frameByte <= '{default: 8'h00};
    end else begin
      byteCnt   <= next_byteCnt;
      frameTgl  <= next_frameTgl;
      frameByte <= next_frameByte;
    end
  end

  // Status read: data change on the falling serial clock edge
  always_comb begin
    readOp  = 1'b1;
    readSel = 8'h00;
    if (frameByte[0] == fhrp_pkg::OP_RDSR1) begin
      readSel = linkStatus[7:0];
    end else if (frameByte[0] == fhrp_pkg::OP_RDSR2) begin
      readSel = linkStatus[15:8];
    end else if (frameByte[0] == fhrp_pkg::OP_RDSR3) begin
      readSel = linkStatus[23:16];
    end else begin
      readOp = 1'b0;
    end
    next_serialOut = serialOut;
    next_linkDrive = linkDrive;
    if (!linkPaused) begin // R5
      next_linkDrive = inFrame && byteCnt != 3'h0 && readOp;
      if (next_linkDrive) begin
        next_serialOut = readSel[~bitCnt[2:0]];
      end
    end
  end

  always_ff @(negedge sclk or posedge linkRst) begin
    if (linkRst) begin
      serialOut <= 1'b0;
      linkDrive <= 1'b0;
    end else begin
      serialOut <= next_serialOut;
      linkDrive <= next_linkDrive;
    end
  end

  // System side
  logic [6:0]         pins;
  logic               csLow, csLowPrev, next_csLowPrev;
  logic               pauseState, next_pause;
  logic               seenFrame, next_seenFrame;
  logic [RCW-1:0]     rstLowCnt, next_rstLowCnt;
  logic               holdFunc, hwRstLow, hwClear, execute, softClear;
  fhrp_pkg::fhrp_op_e opState, next_opState;
  logic [15:0]        timer, next_timer;
  logic [23:0]        nv, next_nv;
  logic               write_enable_latch, next_wel;
  logic               addr_width_flag, next_ads;
  logic               ee, next_ee;
  logic               pe, next_pe;
  logic               dpd, next_dpd;
  logic               rstEn, next_rstEn;
  logic               next_serialOutOe;
  logic [7:0]         op;
  logic [fhrp_pkg::ADDR_W-1:0] addr;
  logic               wholeChip, guardHit, locked;
  logic [23:0]        wrData, wrLane, wrMask;

  fhrp_sync #(.WIDTH(7), .RESET_VAL(fhrp_pkg::SYNC_RESET)) pinSync (
    .clk    (sys_clk),
    .reset  (reset),
    .async  ({frameTgl, linkDrive, sclk, wpN, resetPinN, holdIoN, csN}),
    .synced (pins)
  );

  assign op        = frameByte[0];
  assign addr      = addr_width_flag ? {frameByte[1][0], frameByte[2], frameByte[3], frameByte[4]}
                         : {1'b0, frameByte[1], frameByte[2], frameByte[3]};
  assign wholeChip = (op == fhrp_pkg::OP_CE_A) || (op == fhrp_pkg::OP_CE_B);

  fhrp_area_guard #(.BLOCK_W(fhrp_pkg::BLOCK_W)) areaGuard (
    .guard     (nv[fhrp_pkg::AREA_LSB +: 5]),
    .block     (addr[fhrp_pkg::ADDR_W-1 -: fhrp_pkg::BLOCK_W]),
    .wholeChip (wholeChip),
    .hit       (guardHit)
  ); // R11

  always_comb begin
    csLow    = ~pins[fhrp_pkg::SY_CS];
    holdFunc = ~nv[fhrp_pkg::PINSEL_BIT] & ~nv[fhrp_pkg::QE_BIT]; // R1
    hwRstLow = ~pins[fhrp_pkg::SY_RST] // R8
               | (nv[fhrp_pkg::PINSEL_BIT] & ~nv[fhrp_pkg::QE_BIT] & ~pins[fhrp_pkg::SY_HOLD]); // R7
    hwClear  = rstLowCnt == RCW'(fhrp_pkg::CLEAR_PULSE_CYC); // R9
    next_rstLowCnt = hwRstLow ? (hwClear ? rstLowCnt : rstLowCnt + 1'b1) : '0;
    if (!csLow || !holdFunc) begin
      next_pause = 1'b0;
    end else if (!pauseState) begin
      next_pause = ~pins[fhrp_pkg::SY_HOLD] & ~pins[fhrp_pkg::SY_SCLK]; // R3
    end else begin
      next_pause = ~(pins[fhrp_pkg::SY_HOLD] & ~pins[fhrp_pkg::SY_SCLK]); // R4
    end
    next_csLowPrev = csLow;
    execute = csLowPrev & ~csLow & (pins[fhrp_pkg::SY_FRAME] != seenFrame)
              & ~pauseState & ~hwClear; // R6
    next_seenFrame = (csLowPrev & ~csLow) ? pins[fhrp_pkg::SY_FRAME] : seenFrame;
    locked = nv[fhrp_pkg::STATUS_GUARD_BIT_ONE_BIT] | (nv[fhrp_pkg::STATUS_GUARD_BIT_ZERO_BIT] & ~pins[fhrp_pkg::SY_WP]); // R12
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      csLowPrev  <= 1'b0;
      pauseState <= 1'b0;
      seenFrame  <= 1'b0;
      rstLowCnt  <= '0;
    end else begin
      csLowPrev  <= next_csLowPrev;
      pauseState <= next_pause;
      seenFrame  <= next_seenFrame;
      rstLowCnt  <= next_rstLowCnt;
    end
  end

  always_comb begin
    next_opState = opState;
    next_timer   = timer;
    next_nv      = nv;
    next_wel     = write_enable_latch;
    next_ads     = addr_width_flag;
    next_ee      = ee;
    next_pe      = pe;
    next_dpd     = dpd;
    next_rstEn   = rstEn;
    softClear    = 1'b0;
    wrData       = 24'h000000;
    wrLane       = 24'h000000;
    unique case (op)
      fhrp_pkg::OP_WRSR1: begin
        wrData = {8'h00, frameByte[2], frameByte[1]};
        wrLane = (byteCnt >= 3'h3) ? 24'h00ffff : 24'h0000ff;
      end
      fhrp_pkg::OP_WRSR2: begin
        wrData = {8'h00, frameByte[1], 8'h00};
        wrLane = 24'h00ff00;
      end
      fhrp_pkg::OP_WRSR3: begin
        wrData = {frameByte[1], 16'h0000};
        wrLane = 24'hff0000;
      end
      default: ;
    endcase
    wrMask = wrLane & fhrp_pkg::NV_MASK;
    unique case (opState)
      fhrp_pkg::FHRP_IDLE: ;
      fhrp_pkg::FHRP_BUSY: begin // R2 R17
        if (timer == 16'h0000) begin
          next_opState = fhrp_pkg::FHRP_IDLE;
        end else begin
          next_timer = timer - 16'h0001;
        end
      end
      default: next_opState = fhrp_pkg::FHRP_IDLE;
    endcase
    if (execute && byteCnt != 3'h0) begin
      next_rstEn = op == fhrp_pkg::OP_RST_EN;
      if (op == fhrp_pkg::OP_RST && rstEn) begin
        softClear = 1'b1; // R10
      end else if (dpd) begin // R13
        if (op == fhrp_pkg::OP_DPD_EXIT) begin
          next_dpd = 1'b0;
        end
      end else if (opState == fhrp_pkg::FHRP_IDLE) begin
        unique case (op)
          fhrp_pkg::OP_WRITE_ENABLE_CMD: next_wel = 1'b1; // R10
          fhrp_pkg::OP_WRITE_DISABLE_CMD: next_wel = 1'b0; // R10
          fhrp_pkg::OP_WRSR1, fhrp_pkg::OP_WRSR2, fhrp_pkg::OP_WRSR3: begin
            next_wel = 1'b0; // R10
            if (write_enable_latch && !locked && byteCnt >= 3'h2) begin // R12
              next_nv      = (nv & ~wrMask) | (wrData & wrMask) | (nv & fhrp_pkg::OTP_MASK);
              next_opState = fhrp_pkg::FHRP_BUSY;
              next_timer   = 16'(STATUS_WRITE_CMD_CYC - 1);
            end
          end
          fhrp_pkg::OP_PP: begin
            next_wel = 1'b0; // R10
            if (write_enable_latch) begin
              next_pe = guardHit; // R11
              if (!guardHit) begin
                next_opState = fhrp_pkg::FHRP_BUSY;
                next_timer   = 16'(PROG_CYC - 1);
              end
            end
          end
          fhrp_pkg::OP_SE, fhrp_pkg::OP_BE64, fhrp_pkg::OP_CE_A, fhrp_pkg::OP_CE_B: begin
            next_wel = 1'b0; // R10
            if (write_enable_latch) begin
              next_ee = guardHit; // R11
              if (!guardHit) begin
                next_opState = fhrp_pkg::FHRP_BUSY;
                next_timer   = 16'(ERASE_CYC - 1);
              end
            end
          end
          fhrp_pkg::OP_DPD:  next_dpd = 1'b1;
          fhrp_pkg::OP_EN4B: next_ads = 1'b1;
          fhrp_pkg::OP_EX4B: next_ads = 1'b0;
          default: ;
        endcase
      end
    end
    if (softClear || hwClear) begin // R9
      next_opState = fhrp_pkg::FHRP_IDLE;
      next_timer   = 16'h0000;
      next_wel     = 1'b0;
      next_ads     = nv[fhrp_pkg::ADP_BIT];
      next_ee      = 1'b0;
      next_pe      = 1'b0;
      next_dpd     = 1'b0;
      next_rstEn   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      opState <= fhrp_pkg::FHRP_IDLE;
      timer   <= 16'h0000;
      nv      <= fhrp_pkg::NV_RESET;
      write_enable_latch     <= 1'b0;
      addr_width_flag     <= 1'b0;
      ee      <= 1'b0;
      pe      <= 1'b0;
      dpd     <= 1'b0;
      rstEn   <= 1'b0;
    end else begin
      opState <= next_opState;
      timer   <= next_timer;
      nv      <= next_nv;
      write_enable_latch     <= next_wel;
      addr_width_flag     <= next_ads;
      ee      <= next_ee;
      pe      <= next_pe;
      dpd     <= next_dpd;
      rstEn   <= next_rstEn;
    end
  end

  always_comb begin
    next_statusAll                       = next_nv & fhrp_pkg::NV_MASK; // R14 R15 R16
    next_statusAll[fhrp_pkg::BUSY_BIT]   = next_opState == fhrp_pkg::FHRP_BUSY; // R17
    next_statusAll[fhrp_pkg::WEL_BIT]    = next_wel;
    next_statusAll[fhrp_pkg::ADS_BIT]    = next_ads;
    next_statusAll[fhrp_pkg::PSUS_BIT]   = 1'b0;
    next_statusAll[fhrp_pkg::ESUS_BIT]   = 1'b0;
    next_statusAll[fhrp_pkg::PE_BIT]     = next_pe;
    next_statusAll[fhrp_pkg::EE_BIT]     = next_ee;
    next_serialOutOe = pins[fhrp_pkg::SY_DRIVE] & csLow & ~next_pause; // R5
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      statusAll   <= 24'h000000;
      serialOutOe <= 1'b0;
      paused      <= 1'b0;
    end else begin
      statusAll   <= next_statusAll;
      serialOutOe <= next_serialOutOe;
      paused      <= next_pause;
    end
  end

  assign busy            = statusAll[fhrp_pkg::BUSY_BIT];
  assign statusByteOne   = statusAll[7:0];
  assign statusByteTwo   = statusAll[15:8];
  assign statusByteThree = statusAll[23:16];

  property p_pause_select;
    @(posedge sys_clk) disable iff (reset) paused |-> $past(~pins[fhrp_pkg::SY_CS]);
  endproperty
  a_pause_select: assert property (p_pause_select) else $error("pause without select"); // R3

  property p_pause_entry;
    @(posedge sys_clk) disable iff (reset)
      $rose(paused) |-> $past(~pins[fhrp_pkg::SY_SCLK] & ~pins[fhrp_pkg::SY_HOLD]);
  endproperty
  a_pause_entry: assert property (p_pause_entry) else $error("pause entered with clock high"); // R3

  property p_pause_exit;
    @(posedge sys_clk) disable iff (reset)
      $fell(paused) && $past(csLow && holdFunc) |-> $past(~pins[fhrp_pkg::SY_SCLK]);
  endproperty
  a_pause_exit: assert property (p_pause_exit) else $error("pause left with clock high"); // R4

  property p_pause_float;
    @(posedge sys_clk) disable iff (reset) paused |-> !serialOutOe;
  endproperty
  a_pause_float: assert property (p_pause_float) else $error("output driven while paused"); // R5

  property p_quad_no_pause;
    @(posedge sys_clk) disable iff (reset) $past(nv[fhrp_pkg::QE_BIT]) |-> !paused;
  endproperty
  a_quad_no_pause: assert property (p_quad_no_pause) else $error("pause with quad enable"); // R1

  property p_hw_clear;
    @(posedge sys_clk) disable iff (reset)
      hwClear |-> $past(hwRstLow, 20) ##1 (!write_enable_latch && !dpd && !busy);
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("hardware reset timing wrong"); // R9

  property p_disable_clears;
    @(posedge sys_clk) disable iff (reset)
      execute && op == fhrp_pkg::OP_WRITE_DISABLE_CMD && byteCnt != 3'h0 && !dpd |=> !write_enable_latch && !statusAll[1];
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("latch kept after disable"); // R10

  property p_wp_lock;
    @(posedge sys_clk) disable iff (reset)
      execute && op == fhrp_pkg::OP_WRSR1 && nv[fhrp_pkg::STATUS_GUARD_BIT_ZERO_BIT] && !pins[fhrp_pkg::SY_WP]
      && opState == fhrp_pkg::FHRP_IDLE |=> nv == $past(nv) && !busy;
  endproperty
  a_wp_lock: assert property (p_wp_lock) else $error("status written while locked"); // R12

  property p_dpd_ignore;
    @(posedge sys_clk) disable iff (reset)
      execute && dpd && op == fhrp_pkg::OP_WRITE_ENABLE_CMD |=> write_enable_latch == $past(write_enable_latch) && dpd;
  endproperty
  a_dpd_ignore: assert property (p_dpd_ignore) else $error("command obeyed in power-down"); // R13

  property p_program_busy;
    @(posedge sys_clk) disable iff (reset)
      execute && op == fhrp_pkg::OP_PP && write_enable_latch && !dpd && opState == fhrp_pkg::FHRP_IDLE
      && byteCnt != 3'h0 && !guardHit && !hwClear |=> busy [*8];
  endproperty
  a_program_busy: assert property (p_program_busy) else $error("busy not held"); // R17

  property p_guard_reject;
    @(posedge sys_clk) disable iff (reset)
      execute && op == fhrp_pkg::OP_PP && write_enable_latch && !dpd && opState == fhrp_pkg::FHRP_IDLE
      && byteCnt != 3'h0 && guardHit && !hwClear |=> !busy && pe && !write_enable_latch;
  endproperty
  a_guard_reject: assert property (p_guard_reject) else $error("protected program accepted"); // R11

endmodule : fhrp_flash_guard

// ==== verification/fhrp_host_model.sv ====
module fhrp_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      si,
  output logic      holdIoN,
  input  wire logic serialOut
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclk    = 1'b0;
    csN     = 1'b1;
    si      = 1'b0;
    holdIoN = 1'b1;
  end

  // Select changes only with the link clock parked low
  task automatic sel(input logic v);
    #7 csN = v;
    si = ~si;
  endtask

  // Pause pin moves only while the link clock is low
  task automatic hold(input logic v);
    #15 holdIoN = v;
  endtask

  // Mode 0, MSB first, sampling the reply on the rising edge
  task automatic bits(input logic [7:0] v, input int n, output logic [7:0] r);
    for (int i = 7; i > 7 - n; i--) begin
      si = v[i];
      #15 sclk = 1'b1;
      r = {r[6:0], serialOut};
      #15 sclk = 1'b0;
    end
  endtask
endmodule : fhrp_host_model

// ==== verification/fhrp_flash_guard_tb.sv ====
module fhrp_flash_guard_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, reset, resetPinN, wpN, sclk, csN, si, holdIoN;
  logic        serialOut, serialOutOe, paused, busy, p, e;
  logic [7:0]  sr1, sr2, sr3, r, op;
  logic [4:0]  g;
  logic [31:0] seed;
  logic [7:0]  ops [3] = '{8'h02, 8'h20, 8'hd8};
  int          fail_count, check_count, cyc;

  fhrp_flash_guard #(.STATUS_WRITE_CMD_CYC(8), .PROG_CYC(8), .ERASE_CYC(10)) fhrp_flash_guard_inst (
    .sys_clk(sys_clk), .reset(reset), .sclk(sclk), .csN(csN), .si(si),
    .holdIoN(holdIoN), .resetPinN(resetPinN), .wpN(wpN), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .paused(paused), .busy(busy),
    .statusByteOne(sr1), .statusByteTwo(sr2), .statusByteThree(sr3));
  fhrp_host_model fhrp_host_model_inst (
    .sclk(sclk), .csN(csN), .si(si), .holdIoN(holdIoN), .serialOut(serialOut));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Protected-area lookup for a 64KB block index
  function automatic logic hit(input logic [4:0] gd, input int blk);
    int n;
    n = 1 << (gd[3:0] - 4'h1);
    if (gd[3:0] == 4'h0) return 1'b0;
    if (gd[3] && (gd[2] || gd[1])) return 1'b1;
    return gd[4] ? (blk < n) : (blk >= 512 - n);
  endfunction : hit

  task automatic end_of_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    check_count++;
    if (got !== ex) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Select (onHold 0) or pause pin (onHold 1) of the host model
  task automatic host(input logic onHold, input logic v);
    if (onHold) begin
      fhrp_host_model_inst.hold(v);
    end else begin
      fhrp_host_model_inst.sel(v);
    end
  endtask : host

  task automatic shift(input logic [7:0] v, input int n);
    fhrp_host_model_inst.bits(v, n, r);
  endtask : shift

  task automatic cmd(input logic [7:0] o, input logic [31:0] rest, input int n);
    logic [39:0] b;
    logic [7:0]  q;
    b = {o, rest};
    host(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      fhrp_host_model_inst.bits(b[39-8*i -: 8], 8, q);
    end
    host(1'b0, 1'b1);
    tick(6);
  endtask : cmd

  task automatic status_write_cmd(input logic [7:0] o, input logic [7:0] d, input logic ok);
    cmd(8'h06, 32'h0, 1);
    cmd(o, {d, 24'h0}, 2);
    chk("busy", {7'h0, ok}, {7'h0, busy});
    tick(12);
    chk("latch", 8'h00, {6'h0, sr1[1:0]});
  endtask : status_write_cmd

  task automatic rdsr(input logic [7:0] o, input logic [7:0] ex);
    logic [7:0] q;
    host(1'b0, 1'b0);
    fhrp_host_model_inst.bits(o, 8, q);
    fhrp_host_model_inst.bits(~o, 8, q);
    chk("oe", 8'h01, {7'h0, serialOutOe});
    host(1'b0, 1'b1);
    chk("readback", ex, q);
    tick(6);
  endtask : rdsr

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    {reset, resetPinN, wpN} = 3'b111;
    {fail_count, check_count, cyc} = '0;
    seed = 32'd21731;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    tick(4);
    chk("status", 8'h00, sr1 | sr2 | sr3);
    cmd(8'h06, 32'h0, 1);
    chk("sr1", 8'h02, sr1);
    rdsr(8'h05, 8'h02);
    cmd(8'h04, 32'h0, 1);
    chk("sr1", 8'h00, sr1);
    for (int k = 0; k < 9; k++) begin
      seed = xs(seed);
      g = (k < 2) ? (k ? 5'h0e : 5'h18) : seed[4:0];
      status_write_cmd(8'h01, {1'b0, g, 2'b00}, 1'b1);
      chk("sr1", {1'b0, g, 2'b00}, sr1);
      seed = xs(seed);
      op = ops[k % 3];
      p = hit(g, int'(seed[31:24]));
      cmd(8'h06, 32'h0, 1);
      cmd(op, seed, (op == 8'h02) ? 5 : 4);
      e = (op == 8'h02) ? sr3[2] : sr3[3];
      chk("busy", {7'h0, ~p}, {7'h0, busy});
      chk("fault", {7'h0, p}, {7'h0, e});
      tick(14);
      chk("sr1", {1'b0, g, 2'b00}, sr1);
    end
    status_write_cmd(8'h01, 8'h80, 1'b1);
    @(posedge sys_clk) wpN <= 1'b0;
    status_write_cmd(8'h01, 8'h84, 1'b0);
    chk("sr1", 8'h80, sr1);
    @(posedge sys_clk) wpN <= 1'b1;
    status_write_cmd(8'h01, 8'h00, 1'b1);
    host(1'b0, 1'b0);
    shift(8'h06, 4);
    host(1'b1, 1'b0);
    tick(6);
    chk("paused", 8'h01, {7'h0, paused});
    chk("oe", 8'h00, {7'h0, serialOutOe});
    seed = xs(seed);
    shift(seed[7:0], 4);
    host(1'b1, 1'b1);
    tick(6);
    chk("paused", 8'h00, {7'h0, paused});
    shift(8'h60, 4);
    host(1'b0, 1'b1);
    tick(6);
    chk("sr1", 8'h02, sr1);
    cmd(8'h04, 32'h0, 1);
    host(1'b0, 1'b0);
    shift(8'h06, 8);
    host(1'b1, 1'b0);
    tick(6);
    host(1'b0, 1'b1);
    tick(6);
    host(1'b1, 1'b1);
    tick(6);
    chk("sr1", 8'h00, sr1);
    cmd(8'h06, 32'h0, 1);
    chk("sr1", 8'h02, sr1);
    @(posedge sys_clk) resetPinN <= 1'b0;
    repeat (9) @(posedge sys_clk);
    resetPinN <= 1'b1;
    tick(4);
    chk("sr1", 8'h02, sr1);
    @(posedge sys_clk) resetPinN <= 1'b0;
    repeat (25) @(posedge sys_clk);
    resetPinN <= 1'b1;
    tick(4);
    chk("sr1", 8'h00, sr1);
    cmd(8'hb9, 32'h0, 1);
    cmd(8'h06, 32'h0, 1);
    chk("sr1", 8'h00, sr1);
    cmd(8'hab, 32'h0, 1);
    cmd(8'h06, 32'h0, 1);
    chk("sr1", 8'h02, sr1);
    cmd(8'h66, 32'h0, 1);
    cmd(8'h99, 32'h0, 1);
    chk("sr1", 8'h00, sr1);
    status_write_cmd(8'h11, 8'h80, 1'b1);
    chk("sr3", 8'h80, sr3);
    rdsr(8'h15, 8'h80);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) status_write_cmd(8'h31, 8'h02, 1'b1);
      cmd(8'h06, 32'h0, 1);
      host(1'b1, 1'b0);
      tick(26);
      host(1'b1, 1'b1);
      tick(4);
      chk("sr1", {6'h0, k[0], 1'b0}, sr1);
    end
    chk("sr2", 8'h02, sr2);
    rdsr(8'h35, 8'h02);
    end_of_test();
  end
endmodule : fhrp_flash_guard_tb
